/* File: rtl/tpas_event_log.sv */
`timescale 1ns/1ps
module tpas_event_log
	import tpas_pkg::*;
#(
	parameter int DEPTH        = LOG_DEPTH_DEF,
	parameter bit ALLOW_DELETE = 1'b1,
	parameter int IW           = $clog2(DEPTH)
)(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        clock_en,
	input  wire logic        wr_en,
	input  wire tpas_entry_s wr_entry,
	input  wire logic        del_req,
	input  wire logic [IW-1:0] rd_index,
	output tpas_entry_s      rd_entry,
	output logic [IW:0]      count,
	output logic             del_rejected
);
	// ==========================================================
	// ring of entries, newest at index 0
	tpas_entry_s   mem [DEPTH];
	tpas_entry_s   next_mem [DEPTH];
	tpas_entry_s   next_rd;
	logic [IW-1:0] head;
	logic [IW-1:0] next_head;
	logic [IW:0]   next_count;
	logic          next_rej;
	int            pos;

	always_comb begin
		next_mem   = mem;
		next_head  = head;
		next_count = count;
		next_rej   = 1'b0;
		pos        = int'(head) - 1 - int'(rd_index);
		if (pos < 0)
			pos = pos + DEPTH;
		if (del_req) begin
			if (ALLOW_DELETE)
				next_count = '0;
			else
				next_rej = 1'b1;
		end
		if (wr_en) begin
			next_mem[head] = wr_entry;
			next_head      = (head == IW'(DEPTH - 1)) ? '0 : head + 1'b1;
			if (next_count != (IW+1)'(DEPTH))
				next_count = next_count + 1'b1;
		end
		next_rd = ({1'b0, rd_index} < count) ? mem[pos[IW-1:0]] : '0;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
			head         <= '0;
			count        <= '0;
			del_rejected <= 1'b0;
			rd_entry     <= '0;
		end else if (clock_en) begin
			mem          <= next_mem;
			head         <= next_head;
			count        <= next_count;
			del_rejected <= next_rej;
			rd_entry     <= next_rd;
		end
	end
endmodule

/* File: rtl/tpas_ms_timer.sv */
`timescale 1ns/1ps
module tpas_ms_timer
	import tpas_pkg::*;
#(
	parameter int LIMIT = 50,
	parameter int W     = TMR_W
)(
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic clock_en,
	input  wire logic ms_tick,
	input  wire logic run,
	output logic      done
);
	// ==========================================================
	// restartable millisecond counter
	localparam logic [W-1:0] TERMINAL = W'(LIMIT + 1);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic         next_done;

	always_comb begin
		next_count = count;
		if (!run)
			next_count = '0;
		else if (ms_tick && count != TERMINAL)
			next_count = count + 1'b1;
		next_done = run && (next_count == TERMINAL);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			done  <= 1'b0;
		end else if (clock_en) begin
			count <= next_count;
			done  <= next_done;
		end
	end
endmodule

/* File: rtl/tpas_pkg.sv */
package tpas_pkg;

	// ==========================================================
	// clock and timing
	localparam int  CLK_HZ          = 20_000_000;
	localparam int  MS_PER_S        = 1000;
	localparam int  TICK_CYCLES     = CLK_HZ / MS_PER_S;
	localparam int  GUARD_LOW_MS    = 50;
	localparam int  STARTUP_MS      = 500;
	localparam int  UNBLOCK_MS      = 50;
	localparam int  LONG_BLOCK_MS   = 500;
	localparam real LONG_UNBLOCK_S  = 2.5;
	localparam int  LONG_UNBLOCK_MS = int'(LONG_UNBLOCK_S * MS_PER_S);
	localparam int  SIG_LOSS_MS     = 50;
	localparam int  TMR_W           = 12;

	// ==========================================================
	// timer slots
	localparam int TMR_GLOW   = 0;
	localparam int TMR_SGUARD = 1;
	localparam int TMR_OK     = 2;
	localparam int TMR_OKLONG = 3;
	localparam int TMR_BLK    = 4;
	localparam int TMR_LOSS   = 5;
	localparam int TMR_SSIG   = 6;
	localparam int TMR_NUM    = 7;
	localparam int TMR_LIMIT [0:TMR_NUM-1] = '{GUARD_LOW_MS, STARTUP_MS, UNBLOCK_MS, LONG_UNBLOCK_MS,
		LONG_BLOCK_MS, SIG_LOSS_MS, STARTUP_MS};

	// ==========================================================
	// levels
	localparam int  NOISE_BW_KHZ  = 4;
	localparam int  NOISE_BW_DB   = int'(10.0 * $log10(NOISE_BW_KHZ));
	localparam int  LOW_GUARD_DB  = 5;
	localparam int  EXC_GUARD_DB  = 6;
	localparam int  DB_W          = 8;
	localparam int  CALC_W        = 10;

	// ==========================================================
	// sizes, defaults and log entry kinds
	localparam int       NUM_CMD       = 4;
	localparam int       NUM_ALARM     = 9;
	localparam int       CNT_W_DEF     = 16;
	localparam int       LOG_DEPTH_DEF = 16;
	localparam int       CODE_W        = 8;
	localparam bit [1:0] KIND_SERVICE  = 2'h0;
	localparam bit [1:0] KIND_APPEAR   = 2'h1;
	localparam bit [1:0] KIND_VANISH   = 2'h2;
	localparam bit [1:0] KIND_SECURITY = 2'h3;

	typedef logic signed [DB_W-1:0] tpas_db_t;

	typedef enum logic [1:0] {RX_OPEN, RX_BLOCKED, RX_BLOCKED_LONG} tpas_rx_e;

	typedef struct packed {
		tpas_db_t guard_db;
		tpas_db_t noise_db;
	} tpas_meas_s;

	typedef struct packed {
		tpas_db_t nominal_db;
		tpas_db_t minimum_db;
		tpas_db_t snr_min_db;
	} tpas_cfg_s;

	typedef struct packed {
		logic cfg_error;
		logic manual_block;
		logic dev_error;
		logic test_fail;
		logic exc_guard;
		logic low_guard;
		logic low_snr;
		logic sig_loss;
		logic rx_blocked;
	} tpas_alarm_s;

	typedef struct packed {
		logic [4:0]  day;
		logic [3:0]  month;
		logic [11:0] year;
		logic [4:0]  hour;
		logic [5:0]  minute;
		logic [5:0]  second;
		logic [9:0]  msec;
	} tpas_stamp_s;

	typedef struct packed {
		logic [1:0]        kind;
		logic [CODE_W-1:0] code;
		tpas_stamp_s       stamp;
	} tpas_entry_s;

endpackage

/* File: rtl/tpas_top.sv */
`timescale 1ns/1ps
// How it works
// - management output block forces receiver blocking
// - low guard 50 ms without trip blocks
// - no guard 500 ms after start blocks
// - unblock needs 50 ms continuous guard
// - blocking over 500 ms needs 2.5 s
// - guard gone 50 ms, no command: signal loss
// - no signal 500 ms after start: loss
// - snr below programmed threshold raises alarm
// - snr from nominal guard, noise over 4 kHz
// - guard 5 dB below nominal: low guard
// - guard 6 dB above nominal: excessive guard
// - failed local loop test raises alarm
// - flash, eeprom or rtc fault: device error
// - forced blocking shows manual-blocking alarm meanwhile
// - bad stored configuration at self-check flags alarm
// - per-command transmit and receive counters readable
// - activation counter per input and output
// - live input, output and command flags
// - each alarm red when present, else green
// - user log and separate security log
// - entries carry description and full timestamp
// - security log refuses delete, user log allows
module tpas_top
	import tpas_pkg::*;
#(
	parameter int TICK_DIV  = TICK_CYCLES,
	parameter int CNT_W     = CNT_W_DEF,
	parameter int LOG_DEPTH = LOG_DEPTH_DEF,
	parameter int LIW       = $clog2(LOG_DEPTH)
)(
	input  wire logic                   clock,
	input  wire logic                   reset_n,
	input  wire logic                   clock_en,
	input  wire logic                   mgmt_rx_block,
	input  wire logic                   mgmt_force_block,
	input  wire logic                   guard_present,
	input  wire tpas_meas_s             meas,
	input  wire tpas_cfg_s              cfg,
	input  wire logic [NUM_CMD-1:0]     cmd_tx_active,
	input  wire logic [NUM_CMD-1:0]     cmd_rx_active,
	input  wire logic [NUM_CMD-1:0]     command_input,
	input  wire logic [NUM_CMD-1:0]     command_output,
	input  wire logic                   loop_test_done,
	input  wire logic                   loop_test_pass,
	input  wire logic [2:0]             hw_fault,
	input  wire logic                   selfcheck_done,
	input  wire logic                   selfcheck_cfg_bad,
	input  wire logic                   count_clear,
	input  wire tpas_stamp_s            now,
	input  wire logic                   service_evt,
	input  wire logic [CODE_W-1:0]      service_code,
	input  wire logic                   security_evt,
	input  wire logic [CODE_W-1:0]      security_code,
	input  wire logic                   user_log_delete,
	input  wire logic                   security_log_delete,
	input  wire logic [LIW-1:0]         log_rd_index,
	output tpas_alarm_s                 alarm,
	output logic [NUM_ALARM-1:0]        alarm_red,
	output logic [NUM_ALARM-1:0]        alarm_green,
	output logic [NUM_CMD-1:0][CNT_W-1:0] transmit_counter_row,
	output logic [NUM_CMD-1:0][CNT_W-1:0] receive_counter_row,
	output logic [NUM_CMD-1:0][CNT_W-1:0] input_act_count,
	output logic [NUM_CMD-1:0][CNT_W-1:0] output_act_count,
	output logic [NUM_CMD-1:0]          input_active,
	output logic [NUM_CMD-1:0]          output_active,
	output logic [NUM_CMD-1:0]          cmd_tx_flag,
	output logic [NUM_CMD-1:0]          cmd_rx_flag,
	output tpas_entry_s                 user_log_entry,
	output logic [LIW:0]                user_log_count,
	output tpas_entry_s                 security_log_entry,
	output logic [LIW:0]                security_log_count,
	output logic                        delete_rejected
);
	// ==========================================================
	// decode helpers
	function automatic logic [3:0] first_set(input logic [NUM_ALARM-1:0] v);
		logic [3:0] idx;
		idx = '0;
		for (int i = NUM_ALARM - 1; i >= 0; i--)
			if (v[i])
				idx = 4'(i);
		return idx;
	endfunction

	function automatic logic signed [CALC_W-1:0] wide(input tpas_db_t v);
		return CALC_W'(v);
	endfunction

	// ==========================================================
	// millisecond tick
	localparam int TW = $clog2(TICK_DIV + 1);

	logic [TW-1:0] tick_cnt;
	logic [TW-1:0] next_tick_cnt;
	logic          ms_tick;
	logic          next_ms_tick;

	always_comb begin
		next_tick_cnt = tick_cnt + 1'b1;
		next_ms_tick  = 1'b0;
		if (tick_cnt == TW'(TICK_DIV - 1)) begin
			next_tick_cnt = '0;
			next_ms_tick  = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b0;
		end else if (clock_en) begin
			tick_cnt <= next_tick_cnt;
			ms_tick  <= next_ms_tick;
		end
	end

	// ==========================================================
	// supervision timers
	logic                guard_ok;
	logic                any_rx;
	logic                guard_seen;
	logic                signal_seen;
	logic                next_guard_seen;
	logic                next_signal_seen;
	logic [TMR_NUM-1:0]  tmr_run;
	logic [TMR_NUM-1:0]  tmr_done;
	tpas_rx_e            rx_state;
	tpas_rx_e            next_rx_state;

	assign guard_ok = guard_present && (meas.guard_db >= cfg.minimum_db);
	assign any_rx   = |cmd_rx_active;

	always_comb begin
		next_guard_seen  = guard_seen | guard_present;
		next_signal_seen = signal_seen | guard_present | any_rx;
		tmr_run             = '0;
		tmr_run[TMR_GLOW]   = !guard_ok && !any_rx;
		tmr_run[TMR_SGUARD] = !guard_seen;
		tmr_run[TMR_OK]     = guard_ok;
		tmr_run[TMR_OKLONG] = guard_ok;
		tmr_run[TMR_BLK]    = (rx_state == RX_BLOCKED);
		tmr_run[TMR_LOSS]   = !guard_present && !any_rx;
		tmr_run[TMR_SSIG]   = !signal_seen;
	end

	for (genvar t = 0; t < TMR_NUM; t++) begin : g_tmr
		tpas_ms_timer #(
			.LIMIT (TMR_LIMIT[t]),
			.W     (TMR_W)
		) u_tmr (
			.clock    (clock),
			.reset_n  (reset_n),
			.clock_en (clock_en),
			.ms_tick  (ms_tick),
			.run      (tmr_run[t]),
			.done     (tmr_done[t])
		);
	end

	// ==========================================================
	// receiver blocking state
	logic block_cond;

	assign block_cond = mgmt_rx_block || tmr_done[TMR_GLOW] || tmr_done[TMR_SGUARD];

	always_comb begin
		next_rx_state = rx_state;
		unique case (rx_state)
			RX_OPEN: begin
				if (block_cond)
					next_rx_state = RX_BLOCKED;
			end
			RX_BLOCKED: begin
				if (tmr_done[TMR_BLK])
					next_rx_state = RX_BLOCKED_LONG;
				else if (!block_cond && tmr_done[TMR_OK])
					next_rx_state = RX_OPEN;
			end
			RX_BLOCKED_LONG: begin
				if (!block_cond && tmr_done[TMR_OKLONG])
					next_rx_state = RX_OPEN;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_state    <= RX_OPEN;
			guard_seen  <= 1'b0;
			signal_seen <= 1'b0;
		end else if (clock_en) begin
			rx_state    <= next_rx_state;
			guard_seen  <= next_guard_seen;
			signal_seen <= next_signal_seen;
		end
	end

	// ==========================================================
	// alarms
	logic signed [CALC_W-1:0] snr_db;
	logic                     test_bad;
	logic                     cfg_bad;
	logic                     next_test_bad;
	logic                     next_cfg_bad;
	tpas_alarm_s              next_alarm;

	always_comb begin
		snr_db = wide(cfg.nominal_db) - (wide(meas.noise_db) + CALC_W'(NOISE_BW_DB));
		next_test_bad = loop_test_done ? !loop_test_pass : test_bad;
		next_cfg_bad  = selfcheck_done ? selfcheck_cfg_bad : cfg_bad;
		next_alarm.rx_blocked   = (next_rx_state != RX_OPEN);
		next_alarm.sig_loss     = tmr_done[TMR_LOSS] || tmr_done[TMR_SSIG];
		next_alarm.low_snr      = snr_db < wide(cfg.snr_min_db);
		next_alarm.low_guard    = guard_present &&
			(wide(meas.guard_db) <= wide(cfg.nominal_db) - CALC_W'(LOW_GUARD_DB));
		next_alarm.exc_guard    = guard_present &&
			(wide(meas.guard_db) >= wide(cfg.nominal_db) + CALC_W'(EXC_GUARD_DB));
		next_alarm.test_fail    = next_test_bad;
		next_alarm.dev_error    = |hw_fault;
		next_alarm.manual_block = mgmt_force_block;
		next_alarm.cfg_error    = next_cfg_bad;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			test_bad    <= 1'b0;
			cfg_bad     <= 1'b0;
			alarm       <= '0;
			alarm_red   <= '0;
			alarm_green <= '1;
		end else if (clock_en) begin
			test_bad    <= next_test_bad;
			cfg_bad     <= next_cfg_bad;
			alarm       <= next_alarm;
			alarm_red   <= next_alarm;
			alarm_green <= ~next_alarm;
		end
	end

	// ==========================================================
	// counters and live flags
	for (genvar c = 0; c < NUM_CMD; c++) begin : g_cnt
		logic [3:0]            rise;
		logic [3:0][CNT_W-1:0] cur;
		logic [3:0][CNT_W-1:0] nxt;

		assign rise = {command_output[c] & ~output_active[c], command_input[c] & ~input_active[c],
			cmd_rx_active[c] & ~cmd_rx_flag[c], cmd_tx_active[c] & ~cmd_tx_flag[c]};
		assign cur  = {output_act_count[c], input_act_count[c], receive_counter_row[c],
			transmit_counter_row[c]};

		always_comb begin
			for (int k = 0; k < 4; k++)
				nxt[k] = count_clear ? CNT_W'(rise[k]) : cur[k] + CNT_W'(rise[k]);
		end

		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				transmit_counter_row[c] <= '0;
				receive_counter_row[c]  <= '0;
				input_act_count[c]      <= '0;
				output_act_count[c]     <= '0;
				cmd_tx_flag[c]          <= 1'b0;
				cmd_rx_flag[c]          <= 1'b0;
				input_active[c]         <= 1'b0;
				output_active[c]        <= 1'b0;
			end else if (clock_en) begin
				transmit_counter_row[c] <= nxt[0];
				receive_counter_row[c]  <= nxt[1];
				input_act_count[c]      <= nxt[2];
				output_act_count[c]     <= nxt[3];
				cmd_tx_flag[c]          <= cmd_tx_active[c];
				cmd_rx_flag[c]          <= cmd_rx_active[c];
				input_active[c]         <= command_input[c];
				output_active[c]        <= command_output[c];
			end
		end
	end

	// ==========================================================
	// event logging
	logic [NUM_ALARM-1:0] pend;
	logic [NUM_ALARM-1:0] next_pend;
	logic [NUM_ALARM-1:0] served;
	logic [3:0]           pick;
	logic                 user_wr;
	tpas_entry_s          user_entry;
	tpas_entry_s          sec_entry;
	logic                 user_rej;
	logic                 sec_rej;

	always_comb begin
		pick       = first_set(pend);
		served     = '0;
		user_wr    = 1'b0;
		user_entry = '0;
		if (service_evt) begin
			user_wr    = 1'b1;
			user_entry = '{kind: KIND_SERVICE, code: service_code, stamp: now};
		end else if (|pend) begin
			user_wr      = 1'b1;
			served[pick] = 1'b1;
			user_entry   = '{kind: alarm[pick] ? KIND_APPEAR : KIND_VANISH,
				code: CODE_W'(pick), stamp: now};
		end
		next_pend = (pend & ~served) | (next_alarm ^ alarm);
		sec_entry = '{kind: KIND_SECURITY, code: security_code, stamp: now};
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pend            <= '0;
			delete_rejected <= 1'b0;
		end else if (clock_en) begin
			pend            <= next_pend;
			delete_rejected <= user_rej | sec_rej;
		end
	end

	tpas_event_log #(
		.DEPTH        (LOG_DEPTH),
		.ALLOW_DELETE (1'b1),
		.IW           (LIW)
	) u_user_log (
		.clock        (clock),
		.reset_n      (reset_n),
		.clock_en     (clock_en),
		.wr_en        (user_wr),
		.wr_entry     (user_entry),
		.del_req      (user_log_delete),
		.rd_index     (log_rd_index),
		.rd_entry     (user_log_entry),
		.count        (user_log_count),
		.del_rejected (user_rej)
	);

	tpas_event_log #(
		.DEPTH        (LOG_DEPTH),
		.ALLOW_DELETE (1'b0),
		.IW           (LIW)
	) u_security_log (
		.clock        (clock),
		.reset_n      (reset_n),
		.clock_en     (clock_en),
		.wr_en        (security_evt),
		.wr_entry     (sec_entry),
		.del_req      (security_log_delete),
		.rd_index     (log_rd_index),
		.rd_entry     (security_log_entry),
		.count        (security_log_count),
		.del_rejected (sec_rej)
	);
endmodule

/* File: sim/test_teleprot_alarm_supervisor.sv */
`timescale 1ns/1ps
`define CMP(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module test_teleprot_alarm_supervisor
	import tpas_pkg::*;
;
	// ====
	// stimulus and design
	localparam int          MS  = 20;
	localparam tpas_stamp_s NOW = {5'h16, 4'hc, 12'h7e7, 5'h0d, 6'h3b, 6'h29, 10'h35d};
	localparam tpas_cfg_s   CFG = {8'hf6, 8'he2, 8'h14};
	int                     errors, n_compared;
	logic                   clock, reset_n, mgmt_rx_block, mgmt_force_block, send_guard, guard_present;
	logic [NUM_CMD-1:0]     send_cmd, cmd_rx_active, cmd_tx_active, command_input, command_output;
	logic                   loop_test_done, loop_test_pass, selfcheck_done, selfcheck_cfg_bad, count_clear;
	logic [2:0]             hw_fault;
	tpas_meas_s             meas;
	logic                   service_evt, security_evt, user_log_delete, security_log_delete, delete_rejected;
	logic [CODE_W-1:0]      service_code, security_code;
	tpas_alarm_s            alarm;
	logic [NUM_ALARM-1:0]   alarm_red, alarm_green;
	logic [NUM_CMD-1:0][CNT_W_DEF-1:0] transmit_counter_row, receive_counter_row, input_act_count, output_act_count;
	logic [NUM_CMD-1:0]     input_active, output_active, cmd_tx_flag, cmd_rx_flag;
	tpas_entry_s            user_log_entry, security_log_entry;
	logic [4:0]             user_log_count, security_log_count;
	logic [18:0]            lvl [0:6];

	tpas_remote u_remote (.send_guard(send_guard), .send_cmd(send_cmd), .guard_present(guard_present),
		.cmd_rx_active(cmd_rx_active));

	tpas_top #(.TICK_DIV(MS)) DUT (
		.clock(clock), .reset_n(reset_n), .clock_en(1'b1), .mgmt_rx_block(mgmt_rx_block),
		.mgmt_force_block(mgmt_force_block), .guard_present(guard_present), .meas(meas), .cfg(CFG),
		.cmd_tx_active(cmd_tx_active), .cmd_rx_active(cmd_rx_active), .command_input(command_input),
		.command_output(command_output), .loop_test_done(loop_test_done), .loop_test_pass(loop_test_pass),
		.hw_fault(hw_fault), .selfcheck_done(selfcheck_done), .selfcheck_cfg_bad(selfcheck_cfg_bad),
		.count_clear(count_clear), .now(NOW), .service_evt(service_evt), .service_code(service_code),
		.security_evt(security_evt), .security_code(security_code), .user_log_delete(user_log_delete),
		.security_log_delete(security_log_delete), .log_rd_index(4'h0), .alarm(alarm), .alarm_red(alarm_red),
		.alarm_green(alarm_green), .transmit_counter_row(transmit_counter_row),
		.receive_counter_row(receive_counter_row), .input_act_count(input_act_count),
		.output_act_count(output_act_count), .input_active(input_active), .output_active(output_active),
		.cmd_tx_flag(cmd_tx_flag), .cmd_rx_flag(cmd_rx_flag), .user_log_entry(user_log_entry),
		.user_log_count(user_log_count), .security_log_entry(security_log_entry),
		.security_log_count(security_log_count), .delete_rejected(delete_rejected)
	);

	always #25 clock = ~clock;

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic guard_for(input logic g, input logic [3:0] c, input int ms);
		send_guard = g;
		send_cmd = c;
		tick(ms * MS);
	endtask

	initial begin
		repeat (90000) @(posedge clock);
		errors++;
		tally_and_finish;
	end

	// ====
	// test sequence
	initial begin
		{clock, reset_n, mgmt_rx_block, mgmt_force_block, loop_test_done, loop_test_pass} = '0;
		{selfcheck_done, selfcheck_cfg_bad, count_clear, service_evt, security_evt} = '0;
		{user_log_delete, security_log_delete, hw_fault, send_cmd, cmd_tx_active} = '0;
		{command_input, command_output, service_code, security_code} = '0;
		send_guard = 1'b1;
		meas = {8'hf6, 8'hdb};
		lvl = '{{16'hf6db, 3'b000}, {16'hf1db, 3'b100}, {16'hf2db, 3'b000}, {16'hfcdb, 3'b010},
			{16'hfbdb, 3'b000}, {16'hf6dc, 3'b000}, {16'hf6dd, 3'b001}};
		tick(6);
		reset_n = 1'b1;
		tick(60 * MS);
		// levels: low guard, excessive guard, s/n against nominal plus 4 kHz
		foreach (lvl[i]) begin
			meas = lvl[i][18:3];
			tick(2);
			`CMP("level_alarms", lvl[i][2:0], {alarm.low_guard, alarm.exc_guard, alarm.low_snr})
		end
		for (int v = 1; v >= 0; v--) begin
			{loop_test_pass, selfcheck_cfg_bad, loop_test_done, selfcheck_done} = {~v[0], v[0], 2'b11};
			tick(1);
			{loop_test_done, selfcheck_done} = 2'b00;
			tick(1);
			`CMP("test_fail", v[0], alarm.test_fail)
			`CMP("cfg_error", v[0], alarm.cfg_error)
		end
		for (int i = 0; i <= 3; i++) begin
			hw_fault = 3'(i < 3 ? 1 << i : 0);
			tick(2);
			`CMP("dev_error", (i < 3), alarm.dev_error)
		end
		// counters and live flags
		for (int p = 0; p < NUM_CMD; p++) begin
			{command_input, command_output, cmd_tx_active, send_cmd} = {4{4'(4'hf << p)}};
			tick(1);
			`CMP("flags", {4{4'(4'hf << p)}}, {input_active, output_active, cmd_tx_flag, cmd_rx_flag})
			{command_input, command_output, cmd_tx_active, send_cmd} = '0;
			tick(1);
		end
		for (int k = 0; k < NUM_CMD; k++) begin
			`CMP("tx_rx_count", {2{CNT_W_DEF'(k + 1)}}, {transmit_counter_row[k], receive_counter_row[k]})
			`CMP("act_count", {2{CNT_W_DEF'(k + 1)}}, {input_act_count[k], output_act_count[k]})
		end
		count_clear = 1'b1;
		tick(1);
		count_clear = 1'b0;
		tick(1);
		`CMP("cleared", '0, {transmit_counter_row, receive_counter_row, input_act_count, output_act_count})
		// management block, then guard loss timing
		mgmt_rx_block = 1'b1;
		tick(3);
		`CMP("mgmt_block", 1'b1, alarm.rx_blocked)
		mgmt_rx_block = 1'b0;
		tick(3);
		`CMP("mgmt_release", 1'b0, alarm.rx_blocked)
		guard_for(1'b0, 4'h0, 49);
		`CMP("block_early", 2'b00, {alarm.rx_blocked, alarm.sig_loss})
		tick(4 * MS);
		`CMP("block_late", 2'b11, {alarm.rx_blocked, alarm.sig_loss})
		guard_for(1'b1, 4'h0, 49);
		`CMP("unblock_early", 1'b1, alarm.rx_blocked)
		tick(4 * MS);
		`CMP("unblock_late", 1'b0, alarm.rx_blocked)
		guard_for(1'b0, 4'h0, 40);
		guard_for(1'b1, 4'h0, 2);
		guard_for(1'b0, 4'h0, 40);
		`CMP("timer_restart", 2'b00, {alarm.rx_blocked, alarm.sig_loss})
		guard_for(1'b0, 4'h1, 60);
		`CMP("trip_no_block", 2'b00, {alarm.rx_blocked, alarm.sig_loss})
		guard_for(1'b0, 4'h0, 600);
		`CMP("long_block", 1'b1, alarm.rx_blocked)
		guard_for(1'b1, 4'h0, 100);
		`CMP("long_hold", 1'b1, alarm.rx_blocked)
		tick(2390 * MS);
		`CMP("long_hold_end", 1'b1, alarm.rx_blocked)
		tick(13 * MS);
		`CMP("long_release", 1'b0, alarm.rx_blocked)
		// logs
		tick(5);
		user_log_delete = 1'b1;
		tick(1);
		user_log_delete = 1'b0;
		tick(3);
		`CMP("user_deleted", 5'h00, user_log_count)
		mgmt_force_block = 1'b1;
		tick(4);
		`CMP("manual", 2'b10, {alarm.manual_block, alarm.rx_blocked})
		`CMP("appear_entry", {KIND_APPEAR, CODE_W'(7), NOW}, user_log_entry)
		{service_evt, service_code, security_evt, security_code} = {1'b1, 8'h5a, 1'b1, 8'ha5};
		tick(1);
		{service_evt, security_evt} = 2'b00;
		tick(3);
		`CMP("user_count", 5'h02, user_log_count)
		`CMP("service_entry", {KIND_SERVICE, 8'h5a, NOW}, user_log_entry)
		`CMP("security_entry", {KIND_SECURITY, 8'ha5, NOW}, security_log_entry)
		security_log_delete = 1'b1;
		tick(1);
		security_log_delete = 1'b0;
		tick(1);
		`CMP("refused", 1'b1, delete_rejected)
		`CMP("security_kept", 5'h01, security_log_count)
		// restart, commands only
		reset_n = 1'b0;
		guard_for(1'b0, 4'h1, 1);
		reset_n = 1'b1;
		guard_for(1'b0, 4'h1, 499);
		`CMP("start_early", 2'b00, {alarm.rx_blocked, alarm.sig_loss})
		tick(3 * MS);
		`CMP("start_late", 2'b10, {alarm.rx_blocked, alarm.sig_loss})
		tally_and_finish;
	end
endmodule

/* File: sim/tpas_remote.sv */
`timescale 1ns/1ps
module tpas_remote
	import tpas_pkg::*;
(
	input  wire logic               send_guard,
	input  wire logic [NUM_CMD-1:0] send_cmd,
	output logic                    guard_present,
	output logic [NUM_CMD-1:0]      cmd_rx_active
);
	// ====
	// remote terminal tones
	// guard and trip tones as seen by the local detector
	assign guard_present = send_guard;
	assign cmd_rx_active = send_cmd;
endmodule

/* File: sim/tpas_top_asserts.sv */
`timescale 1ns/1ps
module tpas_top_asserts
	import tpas_pkg::*;
#(
	parameter int CNT_W = CNT_W_DEF
)(
	input wire logic                          clock,
	input wire logic                          reset_n,
	input wire logic                          clock_en,
	input wire logic                          mgmt_rx_block,
	input wire logic                          mgmt_force_block,
	input wire logic                          guard_present,
	input wire tpas_meas_s                    meas,
	input wire tpas_cfg_s                     cfg,
	input wire logic [NUM_CMD-1:0]            command_input,
	input wire logic [2:0]                    hw_fault,
	input wire logic                          count_clear,
	input wire logic                          security_log_delete,
	input wire tpas_alarm_s                   alarm,
	input wire logic [NUM_ALARM-1:0]          alarm_red,
	input wire logic [NUM_ALARM-1:0]          alarm_green,
	input wire logic [NUM_CMD-1:0][CNT_W-1:0] input_act_count,
	input wire logic [NUM_CMD-1:0]            input_active,
	input wire logic                          delete_rejected
);
	// ====
	// alarm and counter checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n || !clock_en);

	chk_mgmt_blocks_rx: assert property (mgmt_rx_block [*3] |-> alarm.rx_blocked)
		else $error("receiver open under management block");
	chk_manual_alarm: assert property (1'b1 |=> alarm.manual_block == $past(mgmt_force_block))
		else $error("manual blocking alarm does not follow forced blocking");
	chk_dev_error: assert property (1'b1 |=> alarm.dev_error == |$past(hw_fault))
		else $error("device error alarm does not follow hardware fault");
	chk_low_guard: assert property (1'b1 |=>
		alarm.low_guard == $past(guard_present && (meas.guard_db <= cfg.nominal_db - LOW_GUARD_DB)))
		else $error("low guard alarm wrong");
	chk_exc_guard: assert property (1'b1 |=>
		alarm.exc_guard == $past(guard_present && (meas.guard_db >= cfg.nominal_db + EXC_GUARD_DB)))
		else $error("excessive guard alarm wrong");
	chk_led_colours: assert property (alarm_red == alarm && alarm_green == ~alarm_red)
		else $error("alarm colours disagree with alarm state");
	chk_input_flag: assert property (1'b1 |=> input_active == $past(command_input))
		else $error("input active flag does not follow input");
	chk_act_count: assert property (command_input[0] && !input_active[0] |=>
		input_act_count[0] == ($past(count_clear) ? CNT_W'(1) : CNT_W'($past(input_act_count[0]) + 1)))
		else $error("input activation count not advanced");
	chk_sec_refuse: assert property (security_log_delete |-> ##2 delete_rejected)
		else $error("security log delete not refused");
endmodule

bind tpas_top tpas_top_asserts #(.CNT_W(CNT_W)) u_chk (
	.clock(clock), .reset_n(reset_n), .clock_en(clock_en), .mgmt_rx_block(mgmt_rx_block),
	.mgmt_force_block(mgmt_force_block), .guard_present(guard_present), .meas(meas), .cfg(cfg),
	.command_input(command_input), .hw_fault(hw_fault), .count_clear(count_clear),
	.security_log_delete(security_log_delete), .alarm(alarm), .alarm_red(alarm_red),
	.alarm_green(alarm_green), .input_act_count(input_act_count), .input_active(input_active),
	.delete_rejected(delete_rejected)
);
